// *** cbmu_defines.svh ***
// Constants of the bit-manipulation datapath: field positions,
// reset values of the byte, address and index registers.
// Assumes inclusion by the package and the modules that need them.
`ifndef CBMU_DEFINES_SVH
`define CBMU_DEFINES_SVH

// Flag positions inside the condition code register
`define CBMU_CCR_C_BIT 3'h0
`define CBMU_CCR_Z_BIT 3'h2

// Reset values
`define CBMU_BYTE_RST 8'h00
`define CBMU_ADDR_RST 16'h0000
`define CBMU_IDX_RST  3'h0

`endif

// *** cbmu_pkg.sv ***
// Types shared by the bit-manipulation datapath modules.
// Assumes cbmu_defines.svh is on the include path.
package cbmu_pkg;

  // Operation codes
  typedef enum logic [3:0] {
    CBMU_SET_BIT_OP    = 4'h0,
    CBMU_CLEAR_BIT_OP  = 4'h1,
    CBMU_INVERT_BIT_OP = 4'h2,
    CBMU_TEST_BIT_OP   = 4'h3,
    CBMU_AND_C_BIT     = 4'h4,
    CBMU_AND_C_INV_BIT = 4'h5,
    CBMU_OR_C_BIT      = 4'h6,
    CBMU_OR_C_INV_BIT  = 4'h7,
    CBMU_XOR_C_BIT     = 4'h8,
    CBMU_XOR_C_INV_BIT = 4'h9,
    CBMU_LOAD_C        = 4'hA,
    CBMU_LOAD_C_INV    = 4'hB,
    CBMU_STORE_C       = 4'hC,
    CBMU_STORE_C_INV   = 4'hD
  } cbmu_op_t;

  // One request from the instruction decoder
  typedef struct packed {
    cbmu_op_t    op;           // Operation
    logic        idx_from_reg; // Index from register low bits
    logic [2:0]  imm_idx;      // Immediate bit index
    logic [7:0]  idx_reg;      // Register holding the bit index
    logic        in_memory;    // Operand is in memory
    logic [7:0]  reg_operand;  // Register operand value
    logic [15:0] mem_addr;     // Memory operand address
  } cbmu_req_t;

  // Result of the bit unit for one operand
  typedef struct packed {
    logic [7:0] new_byte;  // Modified byte
    logic       new_flag;  // New carry or zero value
    logic       wr_byte;   // Byte must be written back
    logic       wr_carry;  // Carry flag updated
    logic       wr_zero;   // Zero flag updated
  } cbmu_res_t;

endpackage

// *** cbmu_bit_unit.sv ***
// Combinational bit unit: one byte, one bit index, one carry in.
// Assumes the caller registers its outputs before they leave the block.
`timescale 1ns/1ps
`include "cbmu_defines.svh"

module cbmu_bit_unit
  import cbmu_pkg::*;
(
  input  wire cbmu_op_t   op,
  input  wire logic [7:0] operand,
  input  wire logic [2:0] idx,
  input  wire logic       carry,
  output cbmu_res_t       res
);

  logic [7:0] mask; // One-hot select of the addressed bit
  logic       sel;  // Addressed bit value

  // Decode index into mask
  always_comb
  begin
    mask = 8'h01 << idx;
    sel  = operand[idx];
  end

  // Per-operation result
  always_comb
  begin
    res = '{new_byte: operand, new_flag: carry, wr_byte: 1'b0,
            wr_carry: 1'b0, wr_zero: 1'b0};
    case (op)
      CBMU_SET_BIT_OP:
      begin
        res.new_byte = operand | mask;
        res.wr_byte  = 1'b1;
      end
      CBMU_CLEAR_BIT_OP:
      begin
        res.new_byte = operand & ~mask;
        res.wr_byte  = 1'b1;
      end
      CBMU_INVERT_BIT_OP:
      begin
        res.new_byte = operand ^ mask;
        res.wr_byte  = 1'b1;
      end
      CBMU_TEST_BIT_OP:
      begin
        res.new_flag = ~sel;
        res.wr_zero  = 1'b1;
      end
      CBMU_AND_C_BIT:     res.new_flag = carry & sel;
      CBMU_AND_C_INV_BIT: res.new_flag = carry & ~sel;
      CBMU_OR_C_BIT:      res.new_flag = carry | sel;
      CBMU_OR_C_INV_BIT:  res.new_flag = carry | ~sel;
      CBMU_XOR_C_BIT:     res.new_flag = carry ^ sel;
      CBMU_XOR_C_INV_BIT: res.new_flag = carry ^ ~sel;
      CBMU_LOAD_C:        res.new_flag = sel;
      CBMU_LOAD_C_INV:    res.new_flag = ~sel;
      CBMU_STORE_C:
      begin
        res.new_byte = carry ? (operand | mask) : (operand & ~mask);
        res.wr_byte  = 1'b1;
      end
      CBMU_STORE_C_INV:
      begin
        res.new_byte = carry ? (operand & ~mask) : (operand | mask);
        res.wr_byte  = 1'b1;
      end
      default: res.new_flag = carry;
    endcase
    // Carry ops are all codes from AND to LOAD_C_INV
    res.wr_carry = (op >= CBMU_AND_C_BIT) && (op <= CBMU_LOAD_C_INV);
  end

endmodule

// *** cbmu_core.sv ***
// Bit-manipulation datapath of the CPU: sequences one request,
// fetches and writes back a memory byte, updates the flags.
// Assumes the decoder holds req stable while req_valid and req_ready,
// and memory answers each strobe with a one-cycle ack on core_clk.
`timescale 1ns/1ps
`include "cbmu_defines.svh"

module cbmu_core
  import cbmu_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Request from the decoder
  input  wire logic        req_valid,
  output      logic        req_ready,
  input  wire cbmu_req_t   req,
  // Condition code register seen by the block
  input  wire logic [7:0]  ccr_in,
  output      logic        ccr_wr_en,
  output      logic [7:0]  ccr_wr_data,
  // General register write-back
  output      logic        reg_wr_en,
  output      logic [7:0]  reg_wr_data,
  // Memory byte access
  output      logic        mem_rd_req,
  output      logic        mem_wr_req,
  output      logic [15:0] mem_addr,
  output      logic [7:0]  mem_wr_data,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rd_data,
  // Completion
  output      logic        done,
  output      logic        illegal
);

  // Sequencer states
  // Register ops run IDLE, EXEC, DONE; memory ops add READ, and WRITE when the byte is written back
  typedef enum logic [2:0] {
    CBMU_IDLE  = 3'b000,
    CBMU_READ  = 3'b001,
    CBMU_EXEC  = 3'b010,
    CBMU_WRITE = 3'b011,
    CBMU_DONE  = 3'b100
  } cbmu_state_t;

  // True for the forms that work on the inverted bit or carry
  // Used to refuse a register index for these forms
  function automatic logic cbmu_is_inverted(input cbmu_op_t op);
    case (op)
      CBMU_AND_C_INV_BIT,
      CBMU_OR_C_INV_BIT,
      CBMU_XOR_C_INV_BIT,
      CBMU_LOAD_C_INV,
      CBMU_STORE_C_INV: cbmu_is_inverted = 1'b1;
      default:          cbmu_is_inverted = 1'b0;
    endcase
  endfunction

  // Replace one flag of the condition code byte, keep the other seven;
  // shared by the carry and zero paths so both merge the same way
  function automatic logic [7:0] cbmu_put_flag(input logic [7:0] flags,
                                               input logic [2:0] pos,
                                               input logic       val);
    logic [7:0] merged; // Flags with one bit replaced
    merged      = flags;
    merged[pos] = val;
    cbmu_put_flag = merged;
  endfunction

  // Reset synchroniser
  // Asserts at once, releases two edges later
  logic rst_meta_r;   // First stage, read only by second stage
  logic rst_sync_r;   // Synchronised reset, active low
  logic rst_core_n;   // Copy used by the rest of the block

  // Sequencer and operand state
  cbmu_state_t state_r, state_nxt;   // Sequencer state
  cbmu_op_t    op_r, op_nxt;         // Latched operation
  logic [2:0]  idx_r, idx_nxt;       // Latched bit index
  logic        mem_r, mem_nxt;       // Operand lives in memory
  logic [7:0]  opnd_r, opnd_nxt;     // Operand byte
  logic [15:0] addr_r, addr_nxt;     // Memory address
  logic [7:0]  wdat_r, wdat_nxt;     // Byte to write back

  // Registered outputs
  // Kept in flops so downstream sees clean one-cycle pulses
  logic        ccr_we_r, ccr_we_nxt;     // Flag write strobe
  logic [7:0]  ccr_dat_r, ccr_dat_nxt;   // Flag write data
  logic        reg_we_r, reg_we_nxt;     // Register write strobe
  logic [7:0]  reg_dat_r, reg_dat_nxt;   // Register write data
  logic        done_r, done_nxt;         // Completion pulse
  logic        ill_r, ill_nxt;           // Illegal request pulse

  // Glue between the handshake, the bit unit and the sequencer
  cbmu_res_t   res;         // Bit unit result
  logic        accept;      // Request taken this cycle
  logic        bad_req;     // Inverted form with register index

  // Release reset through two flip-flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Every other flop resets from this copy, so its release is clean
  // even when rst_n rises close to a clock edge
  assign rst_core_n = rst_sync_r;

  // Bit operation on the captured operand
  // Works on latched copies, so the decoder may move on after the take
  cbmu_bit_unit u_bit_unit (
    .op      (op_r),
    .operand (opnd_r),
    .idx     (idx_r),
    .carry   (ccr_in[`CBMU_CCR_C_BIT]),
    .res     (res)
  );

  // Handshake decode
  // Only IDLE takes a request; every other state refuses it
  always_comb
  begin
    req_ready = (state_r == CBMU_IDLE);
    accept    = req_valid && req_ready;
    // Register-sourced index is not allowed for the inverted forms
    bad_req   = cbmu_is_inverted(req.op) && req.idx_from_reg;
  end

  // Sequencer next-state and datapath next values
  // Everything holds by default; strobes and pulses default low
  always_comb
  begin
    state_nxt   = state_r;
    op_nxt      = op_r;
    idx_nxt     = idx_r;
    mem_nxt     = mem_r;
    opnd_nxt    = opnd_r;
    addr_nxt    = addr_r;
    wdat_nxt    = wdat_r;
    ccr_we_nxt  = 1'b0;
    ccr_dat_nxt = ccr_dat_r;
    reg_we_nxt  = 1'b0;
    reg_dat_nxt = reg_dat_r;
    done_nxt    = 1'b0;
    ill_nxt     = 1'b0;
    case (state_r)
      // Waiting for the decoder
      CBMU_IDLE:
      begin
        if (accept && bad_req)
        begin
          // Rejected: nothing is read or written
          ill_nxt  = 1'b1;
          done_nxt = 1'b1;
        end
        else if (accept)
        begin
          op_nxt   = req.op;
          // Index source select
          idx_nxt  = req.idx_from_reg ? req.idx_reg[2:0] : req.imm_idx;
          mem_nxt  = req.in_memory;
          opnd_nxt = req.reg_operand;
          addr_nxt = req.mem_addr;
          // Memory operands are fetched as a whole byte first
          state_nxt = req.in_memory ? CBMU_READ : CBMU_EXEC;
        end
      end

      // Memory read in flight
      CBMU_READ:
      begin
        // Hold the read strobe until memory answers
        if (mem_ack)
        begin
          opnd_nxt  = mem_rd_data;
          state_nxt = CBMU_EXEC;
        end
      end

      // Operand in hand, result decided here
      CBMU_EXEC:
      begin
        // Flag results rewrite only their own bit of the flags
        if (res.wr_carry)
        begin
          ccr_we_nxt  = 1'b1;
          ccr_dat_nxt = cbmu_put_flag(ccr_in, `CBMU_CCR_C_BIT, res.new_flag);
        end
        else if (res.wr_zero)
        begin
          ccr_we_nxt  = 1'b1;
          ccr_dat_nxt = cbmu_put_flag(ccr_in, `CBMU_CCR_Z_BIT, res.new_flag);
        end

        // Byte results go back where the operand came from
        if (res.wr_byte && mem_r)
        begin
          wdat_nxt  = res.new_byte;
          state_nxt = CBMU_WRITE;
        end
        else if (res.wr_byte)
        begin
          reg_we_nxt  = 1'b1;
          reg_dat_nxt = res.new_byte;
          state_nxt   = CBMU_DONE;
        end
        else
        begin
          // Operand untouched for flag-only results
          state_nxt = CBMU_DONE;
        end
      end

      // Memory write in flight
      CBMU_WRITE:
      begin
        // Hold the write strobe until memory answers
        if (mem_ack)
        begin
          state_nxt = CBMU_DONE;
        end
      end

      // Completion pulse
      CBMU_DONE:
      begin
        // Next request may be taken in the cycle done shows
        done_nxt  = 1'b1;
        state_nxt = CBMU_IDLE;
      end

      // Unused codes fall back to idle
      default:
      begin
        state_nxt = CBMU_IDLE;
      end
    endcase
  end

  // Sequencer and datapath registers
  // Register only; all decisions sit in the next-value process
  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      state_r   <= CBMU_IDLE;
      op_r      <= CBMU_SET_BIT_OP;
      idx_r     <= `CBMU_IDX_RST;
      mem_r     <= 1'b0;
      opnd_r    <= `CBMU_BYTE_RST;
      addr_r    <= `CBMU_ADDR_RST;
      wdat_r    <= `CBMU_BYTE_RST;
      ccr_we_r  <= 1'b0;
      ccr_dat_r <= `CBMU_BYTE_RST;
      reg_we_r  <= 1'b0;
      reg_dat_r <= `CBMU_BYTE_RST;
      done_r    <= 1'b0;
      ill_r     <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      op_r      <= op_nxt;
      idx_r     <= idx_nxt;
      mem_r     <= mem_nxt;
      opnd_r    <= opnd_nxt;
      addr_r    <= addr_nxt;
      wdat_r    <= wdat_nxt;
      ccr_we_r  <= ccr_we_nxt;
      ccr_dat_r <= ccr_dat_nxt;
      reg_we_r  <= reg_we_nxt;
      reg_dat_r <= reg_dat_nxt;
      done_r    <= done_nxt;
      ill_r     <= ill_nxt;
    end
  end

  // Output drive; strobes follow state, data from flip-flops
  // Memory strobes come from the state flop, so they drop in the
  // cycle after the ack without any extra logic
  always_comb
  begin
    mem_rd_req  = (state_r == CBMU_READ);
    mem_wr_req  = (state_r == CBMU_WRITE);
    mem_addr    = addr_r;
    mem_wr_data = wdat_r;
    ccr_wr_en   = ccr_we_r;
    ccr_wr_data = ccr_dat_r;
    reg_wr_en   = reg_we_r;
    reg_wr_data = reg_dat_r;
    done        = done_r;
    illegal     = ill_r;
  end

endmodule

// *** cbmu_core_sva.sv ***
// Port checker for the bit datapath core.
// Assumes binding to cbmu_core; sees its ports only.
`timescale 1ns/1ps
module cbmu_core_sva
  import cbmu_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire cbmu_req_t   req,
  input wire logic [7:0]  ccr_in,
  input wire logic        ccr_wr_en,
  input wire logic [7:0]  ccr_wr_data,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        mem_rd_req,
  input wire logic        mem_wr_req,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wr_data,
  input wire logic        mem_ack,
  input wire logic [7:0]  mem_rd_data,
  input wire logic        done,
  input wire logic        illegal
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Request taken this edge
  wire tk = req_valid && req_ready;
  // Inverted form with register index
  wire bad = req.idx_from_reg && req.op[0] && (req.op >= CBMU_AND_C_INV_BIT);
  reg_lat_a: assert property (tk && !req.in_memory && !bad |-> ##[2:4] done && !illegal)
    else $error("register op did not finish in time");
  reject_a: assert property (tk && bad |-> ##[1:2] done && illegal)
    else $error("inverted op with register index not rejected");
  ill_done_a: assert property (illegal |-> done && !ccr_wr_en && !reg_wr_en)
    else $error("illegal without done or with a write");
  flag_done_a: assert property (ccr_wr_en |=> done)
    else $error("flag write not followed by done");
  ccr_keep_a: assert property (ccr_wr_en |-> ccr_wr_data[7:3] == ccr_in[7:3]
    && ccr_wr_data[1] == ccr_in[1])
    else $error("other flags changed");
  one_dest_a: assert property (!(ccr_wr_en && reg_wr_en))
    else $error("flag and byte written together");
  rd_hold_a: assert property (mem_rd_req && !mem_ack |=> mem_rd_req && $stable(mem_addr))
    else $error("read strobe not held");
  rd_next_a: assert property (mem_rd_req && mem_ack
    |=> !mem_rd_req ##[1:2] (mem_wr_req || ccr_wr_en))
    else $error("no result after memory read");
  wr_hold_a: assert property (mem_wr_req && !mem_ack |=> mem_wr_req && $stable(mem_wr_data))
    else $error("write strobe not held");
  wr_done_a: assert property (mem_wr_req && mem_ack |=> !mem_wr_req ##[1:2] done)
    else $error("no done after memory write");
  cover property (tk && bad);
  cover property (mem_wr_req && mem_ack);
  cover property (ccr_wr_en && ccr_wr_data[2]);
endmodule

// *** tb.sv ***
// Self-checking bench for cbmu_core: table of register ops,
// then rejects, memory ops and a reset in mid-operation.
// Assumes the package and defines header are compiled first.
`timescale 1ns/1ps
module tb
  import cbmu_pkg::*;
;
  // Table row: op, index source, index, carry in, expected byte
  typedef struct {cbmu_op_t op; logic fr; logic [2:0] ix; logic c; logic [7:0] e;} cbmu_row_t;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        req_valid = 1'h0;
  cbmu_req_t   req = '0;
  logic [7:0]  ccr_in = 8'hA8;
  logic        mem_ack = 1'h0;
  logic [7:0]  mem_rd_data = 8'h00;
  logic        req_ready, ccr_wr_en, reg_wr_en, mem_rd_req, mem_wr_req, done, illegal;
  logic [7:0]  ccr_wr_data, reg_wr_data, mem_wr_data;
  logic [15:0] mem_addr, a_seen;
  logic [7:0]  cap_c, cap_r, got_c, got_r, got_i, w_seen, nwr, m_byte;
  int          err_total, n_tests, lat, wcnt;
  logic        bop;
  // Operand A5 throughout; flags base A8 keeps C and Z clear
  cbmu_row_t rows [15] = '{
    '{CBMU_SET_BIT_OP,    1'h1, 3'h1, 1'h0, 8'hA7},
    '{CBMU_CLEAR_BIT_OP,  1'h0, 3'h0, 1'h0, 8'hA4},
    '{CBMU_INVERT_BIT_OP, 1'h1, 3'h7, 1'h0, 8'h25},
    '{CBMU_TEST_BIT_OP,   1'h1, 3'h3, 1'h1, 8'hAD},
    '{CBMU_TEST_BIT_OP,   1'h0, 3'h0, 1'h0, 8'hA8},
    '{CBMU_AND_C_BIT,     1'h1, 3'h2, 1'h1, 8'hA9},
    '{CBMU_AND_C_INV_BIT, 1'h0, 3'h2, 1'h1, 8'hA8},
    '{CBMU_OR_C_BIT,      1'h0, 3'h6, 1'h1, 8'hA9},
    '{CBMU_OR_C_INV_BIT,  1'h0, 3'h6, 1'h0, 8'hA9},
    '{CBMU_XOR_C_BIT,     1'h0, 3'h5, 1'h1, 8'hA8},
    '{CBMU_XOR_C_INV_BIT, 1'h0, 3'h5, 1'h1, 8'hA9},
    '{CBMU_LOAD_C,        1'h0, 3'h4, 1'h1, 8'hA8},
    '{CBMU_LOAD_C_INV,    1'h0, 3'h4, 1'h0, 8'hA9},
    '{CBMU_STORE_C,       1'h1, 3'h3, 1'h1, 8'hAD},
    '{CBMU_STORE_C_INV,   1'h0, 3'h0, 1'h1, 8'hA4}};
  cbmu_op_t inv [5] = '{CBMU_AND_C_INV_BIT, CBMU_OR_C_INV_BIT, CBMU_XOR_C_INV_BIT,
                        CBMU_LOAD_C_INV, CBMU_STORE_C_INV};

  cbmu_core u_cbmu_core (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .req_valid   (req_valid),
    .req_ready   (req_ready),
    .req         (req),
    .ccr_in      (ccr_in),
    .ccr_wr_en   (ccr_wr_en),
    .ccr_wr_data (ccr_wr_data),
    .reg_wr_en   (reg_wr_en),
    .reg_wr_data (reg_wr_data),
    .mem_rd_req  (mem_rd_req),
    .mem_wr_req  (mem_wr_req),
    .mem_addr    (mem_addr),
    .mem_wr_data (mem_wr_data),
    .mem_ack     (mem_ack),
    .mem_rd_data (mem_rd_data),
    .done        (done),
    .illegal     (illegal)
  );

  always #10 core_clk = ~core_clk;

  // Memory side: ack after lat wait cycles; data inverted while ack is low
  always @(posedge core_clk)
  begin
    #2;
    if (mem_ack || !(mem_rd_req || mem_wr_req))
    begin
      mem_ack = 1'h0;
      wcnt = 0;
    end
    else if (wcnt < lat)
      wcnt++;
    else
    begin
      mem_ack = 1'h1;
      a_seen = mem_addr;
      if (mem_wr_req)
      begin
        w_seen = mem_wr_data;
        nwr++;
      end
    end
    mem_rd_data = mem_ack ? m_byte : ~m_byte;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Wrong source field holds the inverted index, so a mix-up shows
  function automatic cbmu_req_t mk(cbmu_op_t o, logic f, logic [2:0] i, logic m);
    mk = '{op: o, idx_from_reg: f, imm_idx: f ? ~i : i, idx_reg: {5'h1F, f ? i : ~i},
           in_memory: m, reg_operand: 8'hA5, mem_addr: 16'h3C5A};
  endfunction

  // One request; logs every flag and register write pulse until done
  task automatic go(input cbmu_req_t r);
    int k;
    got_c = 8'h00;
    got_r = 8'h00;
    // Let an edge pass so a back-to-back call never rewrites req_valid
    @(posedge core_clk) #2;
    for (k = 0; k < 40 && !req_ready; k++) @(posedge core_clk) #2;
    req = r;
    req_valid = 1'h1;
    @(posedge core_clk) #2;
    req_valid = 1'h0;
    for (k = 0; k < 80 && done !== 1'h1; k++)
    begin
      if (ccr_wr_en) begin cap_c = ccr_wr_data; got_c++; end
      if (reg_wr_en) begin cap_r = reg_wr_data; got_r++; end
      @(posedge core_clk) #2;
    end
    got_i = {7'h00, illegal};
    chk(done, 1'h1);
  endtask

  task automatic rel();
    repeat (8) @(posedge core_clk);
    #2 rst_n = 1'h1;
    repeat (3) @(posedge core_clk);
    #2;
  endtask

  initial
  begin
    #100000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    lat = 0;
    nwr = 8'h00;
    m_byte = 8'h5A;
    rel();
    chk({req_ready, ccr_wr_en, reg_wr_en, mem_rd_req, mem_wr_req, done}, 16'h20);
    foreach (rows[i])
    begin
      ccr_in = 8'hA8 | {7'h00, rows[i].c};
      go(mk(rows[i].op, rows[i].fr, rows[i].ix, 1'h0));
      bop = rows[i].op inside {[CBMU_SET_BIT_OP:CBMU_INVERT_BIT_OP], CBMU_STORE_C,
                               CBMU_STORE_C_INV};
      chk({got_r, got_c}, bop ? 16'h0100 : 16'h0001);
      chk(bop ? cap_r : cap_c, rows[i].e);
    end
    // Inverted forms asked with a register index
    foreach (inv[i])
    begin
      go(mk(inv[i], 1'h1, 3'h2, 1'h0));
      chk({got_i, got_r}, 16'h0100);
      chk({8'h00, got_c}, 16'h0000);
    end
    // Memory invert, slow memory
    lat = 3;
    go(mk(CBMU_INVERT_BIT_OP, 1'h0, 3'h0, 1'h1));
    chk(w_seen, 8'h5B);
    chk(a_seen, 16'h3C5A);
    chk({nwr, got_r}, 16'h0100);
    // Memory test: flag only, no write back
    ccr_in = 8'hA8;
    go(mk(CBMU_TEST_BIT_OP, 1'h0, 3'h5, 1'h1));
    chk({nwr, cap_c}, 16'h01AC);
    // Memory store with register index, prompt memory
    lat = 0;
    ccr_in = 8'hA9;
    go(mk(CBMU_STORE_C, 1'h1, 3'h7, 1'h1));
    chk({nwr, w_seen}, 16'h02DA);
    // Reset while waiting on a slow read
    lat = 20;
    req = mk(CBMU_SET_BIT_OP, 1'h0, 3'h1, 1'h1);
    req_valid = 1'h1;
    @(posedge core_clk) #2;
    req_valid = 1'h0;
    repeat (4) @(posedge core_clk);
    #2 rst_n = 1'h0;
    #1 chk({req_ready, mem_rd_req, done}, 16'h4);
    rel();
    lat = 1;
    go(mk(CBMU_SET_BIT_OP, 1'h0, 3'h2, 1'h1));
    chk({nwr, w_seen}, 16'h035E);
    report_and_stop();
  end
endmodule

bind cbmu_core cbmu_core_sva u_sva (.*);
